/* hw/ubc_channel.sv */
// Transmit time-guard and receive/transmit buffer transfer channels
//
// Functional notes
// - Guard value zero adds no idle time
// - Guard 1..255 holds line high that many bits
// - Receive count zero halts receive transfers
// - Nonzero receive count moves char when available
// - Transmit count zero halts transmit fetches
// - Nonzero transmit count fetches when holding free
// - Receive available set while unread char present
// - Holding free set when empty, no break
// - Receive done bit mirrors receive end-of-transfer
// - Transmit done bit mirrors transmit end-of-transfer
//
// Register access over Wishbone was decided locally.
`default_nettype none
module ubc_channel
    import ubc_pkg::*;
#(
    parameter logic [31:0] CHAR_BYTES = 32'h0000_0001
)
(
    input wire logic sys_clk,
    input wire logic rst,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port core side
    input wire logic bit_tick,
    input wire logic tx_char_sent,
    input wire logic rx_char_available,
    input wire logic [8:0] rx_char_data,
    input wire logic tx_holding_free,
    output logic rx_char_read,
    output logic tx_char_write,
    output logic [8:0] tx_char_data,
    output logic tx_guard_hold,
    output logic rx_transfer_done,
    output logic tx_transfer_done,
    // Memory master
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [8:0] mem_wdata,
    input wire logic [8:0] mem_rdata,
    input wire logic mem_ack
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Byte-lane merge of a bus write into an old value
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] guard_interval_reg, guard_interval_next; // guard value
    logic [31:0] rx_buffer_location_reg, rx_buffer_location_next;
    logic [15:0] rx_remaining_count_reg, rx_remaining_count_next;
    logic [31:0] tx_buffer_location_reg, tx_buffer_location_next;
    logic [15:0] tx_remaining_count_reg, tx_remaining_count_next;
    logic [31:0] wb_dat_reg, wb_dat_next; // read data
    logic wb_ack_reg, wb_ack_next; // single-cycle ack
    logic [7:0] guard_cnt_reg, guard_cnt_next; // bit periods left
    logic guard_hold_reg, guard_hold_next; // line forced idle
    ubc_state_t state_reg, state_next; // channel sequencer
    logic rx_read_reg, rx_read_next; // pop pulse to receiver
    logic tx_write_reg, tx_write_next; // push pulse to transmitter
    logic [8:0] tx_data_reg, tx_data_next; // char for holding reg
    logic mem_req_reg, mem_req_next; // memory request
    logic mem_we_reg, mem_we_next; // memory direction
    logic [31:0] mem_addr_reg, mem_addr_next; // memory address
    logic [8:0] mem_wdata_reg, mem_wdata_next; // memory write data
    logic rx_done_reg, rx_done_next; // receive end-of-transfer
    logic tx_done_reg, tx_done_next; // transmit end-of-transfer
    logic bus_hit; // bus access taken this cycle
    logic bus_wr; // bus write taken this cycle

    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_reg;
    assign bus_wr = bus_hit && wb_we_i;

    // ----------------------------------------------------------------
    // Bus slave and register file
    // ----------------------------------------------------------------

    // Decode, byte-lane writes, read mux; unmapped reads zero
    always_comb
    begin
        logic [31:0] stat;
        stat = UBC_RST_ZERO;
        stat[UBC_ST_RXAV] = rx_char_available;
        stat[UBC_ST_TXHF] = tx_holding_free;
        stat[UBC_ST_RXDN] = rx_done_reg;
        stat[UBC_ST_TXDN] = tx_done_reg;
        stat[UBC_ST_GRD] = guard_hold_reg;
        guard_interval_next = guard_interval_reg;
        rx_buffer_location_next = rx_buffer_location_reg;
        rx_remaining_count_next = rx_remaining_count_reg;
        tx_buffer_location_next = tx_buffer_location_reg;
        tx_remaining_count_next = tx_remaining_count_reg;
        wb_ack_next = bus_hit; // ack one cycle after request, then drop
        wb_dat_next = UBC_RST_ZERO;
        // Channel progress: advance address, count down on each move
        if (state_reg == UBC_RXWR && mem_ack)
        begin
            rx_buffer_location_next =
                rx_buffer_location_reg + CHAR_BYTES;
            rx_remaining_count_next = rx_remaining_count_reg - 16'h0001;
        end
        if (state_reg == UBC_TXRD && mem_ack)
        begin
            tx_buffer_location_next =
                tx_buffer_location_reg + CHAR_BYTES;
            tx_remaining_count_next = tx_remaining_count_reg - 16'h0001;
        end
        // Software write wins over a concurrent channel update
        if (bus_wr)
        begin
            unique case (wb_adr_i)
                // Upper lanes fall away: the field keeps eight bits
                UBC_OFF_GUARD: guard_interval_next = 8'(lane_merge(
                    {24'h00_0000, guard_interval_reg}, wb_dat_i, wb_sel_i));
                UBC_OFF_RXADR: rx_buffer_location_next =
                    lane_merge(rx_buffer_location_reg, wb_dat_i, wb_sel_i);
                UBC_OFF_RXCNT: rx_remaining_count_next = 16'(lane_merge(
                    {16'h0000, rx_remaining_count_reg}, wb_dat_i, wb_sel_i));
                UBC_OFF_TXADR: tx_buffer_location_next =
                    lane_merge(tx_buffer_location_reg, wb_dat_i, wb_sel_i);
                UBC_OFF_TXCNT: tx_remaining_count_next = 16'(lane_merge(
                    {16'h0000, tx_remaining_count_reg}, wb_dat_i, wb_sel_i));
                default: ; // Unmapped or read-only: write ignored
            endcase
        end
        if (bus_hit && !wb_we_i)
        begin
            unique case (wb_adr_i)
                UBC_OFF_GUARD: wb_dat_next = {24'h00_0000, guard_interval_reg};
                UBC_OFF_RXADR: wb_dat_next = rx_buffer_location_reg;
                UBC_OFF_RXCNT: wb_dat_next =
                    {16'h0000, rx_remaining_count_reg};
                UBC_OFF_TXADR: wb_dat_next = tx_buffer_location_reg;
                UBC_OFF_TXCNT: wb_dat_next =
                    {16'h0000, tx_remaining_count_reg};
                UBC_OFF_STAT: wb_dat_next = stat;
                default: wb_dat_next = UBC_RST_ZERO; // Unmapped reads zero
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            guard_interval_reg <= UBC_RST_GUARD;
            rx_buffer_location_reg <= UBC_RST_ZERO;
            rx_remaining_count_reg <= UBC_RST_CNT;
            tx_buffer_location_reg <= UBC_RST_ZERO;
            tx_remaining_count_reg <= UBC_RST_CNT;
            wb_dat_reg <= UBC_RST_ZERO;
            wb_ack_reg <= 1'b0;
        end
        else
        begin
            guard_interval_reg <= guard_interval_next;
            rx_buffer_location_reg <= rx_buffer_location_next;
            rx_remaining_count_reg <= rx_remaining_count_next;
            tx_buffer_location_reg <= tx_buffer_location_next;
            tx_remaining_count_reg <= tx_remaining_count_next;
            wb_dat_reg <= wb_dat_next;
            wb_ack_reg <= wb_ack_next;
        end
    end

    // ----------------------------------------------------------------
    // Transmit time-guard
    // ----------------------------------------------------------------

    // Load on each sent character, count down on baud ticks
    always_comb
    begin
        guard_cnt_next = guard_cnt_reg;
        if (tx_char_sent)
        begin
            guard_cnt_next = guard_interval_reg;
        end
        else if (bit_tick && guard_cnt_reg != 8'h00)
        begin
            guard_cnt_next = guard_cnt_reg - 8'h01;
        end
        // Zero value never raises the hold, so no gap is added
        guard_hold_next = (guard_cnt_next != 8'h00);
    end

    // Guard flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            guard_cnt_reg <= 8'h00;
            guard_hold_reg <= 1'b0;
        end
        else
        begin
            guard_cnt_reg <= guard_cnt_next;
            guard_hold_reg <= guard_hold_next;
        end
    end

    // ----------------------------------------------------------------
    // Transfer sequencer
    // ----------------------------------------------------------------

    // Receive has priority: an unread char risks overrun sooner
    always_comb
    begin
        state_next = state_reg;
        rx_read_next = 1'b0;
        tx_write_next = 1'b0;
        tx_data_next = tx_data_reg;
        mem_req_next = mem_req_reg;
        mem_we_next = mem_we_reg;
        mem_addr_next = mem_addr_reg;
        mem_wdata_next = mem_wdata_reg;
        unique case (state_reg)
            UBC_IDLE:
            begin
                // Zero counts keep both channels halted
                if (rx_remaining_count_reg != 16'h0000
                    && rx_char_available)
                begin
                    state_next = UBC_RXWR;
                    // Pop now so the flag is down on return
                    rx_read_next = 1'b1;
                    mem_req_next = 1'b1;
                    mem_we_next = 1'b1;
                    mem_addr_next = rx_buffer_location_reg;
                    mem_wdata_next = rx_char_data;
                end
                else if (tx_remaining_count_reg != 16'h0000
                    && tx_holding_free)
                begin
                    state_next = UBC_TXRD;
                    mem_req_next = 1'b1;
                    mem_we_next = 1'b0;
                    mem_addr_next = tx_buffer_location_reg;
                end
            end
            UBC_RXWR:
            begin
                if (mem_ack)
                begin
                    state_next = UBC_IDLE;
                    mem_req_next = 1'b0;
                    mem_we_next = 1'b0;
                end
            end
            UBC_TXRD:
            begin
                if (mem_ack)
                begin
                    state_next = UBC_TXST;
                    mem_req_next = 1'b0;
                    tx_write_next = 1'b1;
                    tx_data_next = mem_rdata;
                end
            end
            UBC_TXST:
            begin
                // One cycle for the holding-free flag to fall
                state_next = UBC_IDLE;
            end
            default: state_next = UBC_IDLE;
        endcase
        rx_done_next = (rx_remaining_count_next == 16'h0000);
        tx_done_next = (tx_remaining_count_next == 16'h0000);
    end

    // Sequencer flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= UBC_IDLE;
            rx_read_reg <= 1'b0;
            tx_write_reg <= 1'b0;
            tx_data_reg <= 9'h000;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= UBC_RST_ZERO;
            mem_wdata_reg <= 9'h000;
            rx_done_reg <= 1'b1;
            tx_done_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            rx_read_reg <= rx_read_next;
            tx_write_reg <= tx_write_next;
            tx_data_reg <= tx_data_next;
            mem_req_reg <= mem_req_next;
            mem_we_reg <= mem_we_next;
            mem_addr_reg <= mem_addr_next;
            mem_wdata_reg <= mem_wdata_next;
            rx_done_reg <= rx_done_next;
            tx_done_reg <= tx_done_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign wb_dat_o = wb_dat_reg;
    assign wb_ack_o = wb_ack_reg;
    assign rx_char_read = rx_read_reg;
    assign tx_char_write = tx_write_reg;
    assign tx_char_data = tx_data_reg;
    assign tx_guard_hold = guard_hold_reg;
    assign rx_transfer_done = rx_done_reg;
    assign tx_transfer_done = tx_done_reg;
    assign mem_req = mem_req_reg;
    assign mem_we = mem_we_reg;
    assign mem_addr = mem_addr_reg;
    assign mem_wdata = mem_wdata_reg;

endmodule
`default_nettype wire

/* hw/ubc_pkg.sv */
// Package with register map, field layout and reset values of the channel
`default_nettype none
package ubc_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] UBC_OFF_GUARD = 8'h28; // tx_guard_time
    localparam logic [7:0] UBC_OFF_RXADR = 8'h30; // rx_buffer_address
    localparam logic [7:0] UBC_OFF_RXCNT = 8'h34; // rx_transfer_count
    localparam logic [7:0] UBC_OFF_TXADR = 8'h38; // tx_buffer_address
    localparam logic [7:0] UBC_OFF_TXCNT = 8'h3c; // tx_transfer_count
    localparam logic [7:0] UBC_OFF_STAT = 8'h40; // channel_status, read only

    // ----------------------------------------------------------------
    // Field widths and status bit positions
    // ----------------------------------------------------------------
    localparam int UBC_GUARD_W = 8; // guard_interval width
    localparam int UBC_CNT_W = 16; // remaining count width
    localparam int UBC_ST_RXAV = 0; // rx_char_available
    localparam int UBC_ST_TXHF = 1; // tx_holding_free
    localparam int UBC_ST_RXDN = 3; // rx_transfer_done
    localparam int UBC_ST_TXDN = 4; // tx_transfer_done
    localparam int UBC_ST_GRD = 5; // guard interval running

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] UBC_RST_ZERO = 32'h0000_0000;
    localparam logic [7:0] UBC_RST_GUARD = 8'h00;
    localparam logic [15:0] UBC_RST_CNT = 16'h0000;

    // Channel sequencer states, one-hot
    typedef enum logic [3:0] {
        UBC_IDLE = 4'b0001,
        UBC_RXWR = 4'b0010,
        UBC_TXRD = 4'b0100,
        UBC_TXST = 4'b1000
    } ubc_state_t;

endpackage
`default_nettype wire

/* verification/ubc_mem_model.sv */
// Memory bus partner that answers channel fetches and stores
`default_nettype none
module ubc_mem_model
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [8:0] mem_wdata,
    output logic [8:0] mem_rdata,
    output var logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] mem [16]; // Small store, address wraps at 16
    logic [3:0] wait_reg; // Cycles waited on this request
    // Answer after lat cycles; ack is a single-cycle pulse
    always @(posedge sys_clk)
    begin
        if (rst || !mem_req || mem_ack)
        begin
            wait_reg <= 4'h0;
            mem_ack <= 1'b0;
        end
        else if (wait_reg == lat)
        begin
            mem_ack <= 1'b1;
            if (mem_we)
                mem[mem_addr[3:0]] <= mem_wdata;
        end
        else
            wait_reg <= wait_reg + 4'h1;
    end
    // Outside ack the data is inverted, so a stale sample shows up
    assign mem_rdata = mem_ack ? mem[mem_addr[3:0]] : ~mem[mem_addr[3:0]];
endmodule
`default_nettype wire

/* verification/ubc_channel_monitor.sv */
// Port-level checks of the buffer channel and time-guard
`default_nettype none
module ubc_channel_monitor
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic bit_tick,
    input wire logic tx_char_sent,
    input wire logic rx_char_read,
    input wire logic tx_char_write,
    input wire logic [8:0] tx_char_data,
    input wire logic tx_guard_hold,
    input wire logic rx_transfer_done,
    input wire logic tx_transfer_done,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [8:0] mem_rdata,
    input wire logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Steps of the handshakes
    // ----------------------------------------------------------------
    sequence s_bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_fetch_done;
        mem_req && !mem_we && mem_ack;
    endsequence
    bus_answer_a: assert property (s_bus_req |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    rx_halt_a: assert property (rx_char_read |-> !rx_transfer_done)
        else $error("receive move with zero count");
    rx_move_a: assert property (rx_char_read |-> mem_req && mem_we)
        else $error("receive pop without memory store");
    tx_halt_a: assert property (mem_req && !mem_we
        |-> !tx_transfer_done)
        else $error("transmit fetch with zero count");
    tx_fetch_a: assert property (s_fetch_done |=> tx_char_write
        && tx_char_data == $past(mem_rdata))
        else $error("fetched char not written to holding");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req
        && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    guard_start_a: assert property ($rose(tx_guard_hold)
        |-> $past(tx_char_sent))
        else $error("guard started without sent char");
    guard_end_a: assert property ($fell(tx_guard_hold)
        |-> $past(bit_tick))
        else $error("guard ended off a bit period");
endmodule
bind ubc_channel ubc_channel_monitor u_mon (.sys_clk, .rst, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .bit_tick, .tx_char_sent, .rx_char_read,
    .tx_char_write, .tx_char_data, .tx_guard_hold, .rx_transfer_done,
    .tx_transfer_done, .mem_req, .mem_we, .mem_addr, .mem_rdata, .mem_ack);
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench for the buffer channel and time-guard
`default_nettype none
module tb
    import ubc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d, r, e;} ubc_row_t;
    // Address, write data, reset value, read-back value
    // Status first, while both counts still read zero; its write is ignored
    ubc_row_t rows [7] = '{
        '{UBC_OFF_STAT, 32'hffff_ffff, 32'h0000_0018, 32'h0000_0018},
        '{UBC_OFF_GUARD, 32'h0000_01ff, 32'h0, 32'h0000_00ff},
        '{UBC_OFF_RXADR, 32'h1234_5678, 32'h0, 32'h1234_5678},
        '{UBC_OFF_RXCNT, 32'h0001_0003, 32'h0, 32'h0000_0003},
        '{UBC_OFF_TXADR, 32'h0000_0101, 32'h0, 32'h0000_0101},
        '{UBC_OFF_TXCNT, 32'hffff_ffff, 32'h0, 32'h0000_ffff},
        '{8'h50, 32'h5a5a_5a5a, 32'h0, 32'h0}}; // Unmapped
    logic [7:0] gv [2] = '{8'h03, 8'h00}; // Guard lengths tried
    logic sys_clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0, bit_tick = 1'b0, tx_char_sent = 1'b0;
    logic rx_char_available = 1'b0, tx_holding_free = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf; // Full words only
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd, mem_addr;
    logic [8:0] rx_char_data = 9'h1a5, tx_char_data, mem_rdata, mem_wdata;
    logic [8:0] txq [4]; // Chars handed to the transmitter
    logic wb_ack_o, rx_char_read, tx_char_write, tx_guard_hold, mem_ack;
    logic rx_transfer_done, tx_transfer_done, mem_req, mem_we;
    logic [3:0] mem_lat = 4'h3; // Memory answer delay
    logic [1:0] tick_cnt = 2'b00; // Bit period is four clocks
    int fail_count = 0, n_tests = 0, rd_n = 0, tx_n = 0, tk_n = 0, k;
    ubc_channel u_dut (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .bit_tick,
        .tx_char_sent, .rx_char_available, .rx_char_data, .tx_holding_free,
        .rx_char_read, .tx_char_write, .tx_char_data, .tx_guard_hold,
        .rx_transfer_done, .tx_transfer_done, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_rdata, .mem_ack);
    ubc_mem_model u_mem (.sys_clk, .rst, .lat(mem_lat), .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    always #50 sys_clk = ~sys_clk;
    // Receiver offers a new char after each pop; count port events
    always @(posedge sys_clk)
    begin
        tick_cnt <= tick_cnt + 2'b01;
        bit_tick <= (tick_cnt == 2'b11);
        if (rx_char_read === 1'b1)
        begin
            rd_n <= rd_n + 1;
            rx_char_data <= rx_char_data + 9'h001;
        end
        if (tx_char_write === 1'b1)
        begin
            txq[tx_n] <= tx_char_data;
            tx_n <= tx_n + 1;
        end
        if (tx_guard_hold === 1'b1 && bit_tick === 1'b1)
            tk_n <= tk_n + 1;
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Classic single cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        u_mem.mem[8] = 9'h0c3;
        u_mem.mem[9] = 9'h13c;
        cyc(20);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            rdc("reset value", rows[i].a, rows[i].r);
            wb(1'b1, rows[i].a, rows[i].d);
            rdc("read back", rows[i].a, rows[i].e);
        end
        // Receive two chars through a slow memory, then stay halted
        wb(1'b1, UBC_OFF_RXADR, 32'h0000_0004);
        wb(1'b1, UBC_OFF_RXCNT, 32'h0000_0002);
        rx_char_available <= 1'b1;
        while (rd_n < 2 || rx_transfer_done !== 1'b1)
            @(posedge sys_clk);
        cyc(20);
        chk("rx moves", 32'(rd_n), 32'd2);
        chk("rx mem 4", 32'(u_mem.mem[4]), 32'h0000_01a5);
        chk("rx mem 5", 32'(u_mem.mem[5]), 32'h0000_01a6);
        rdc("rx addr", UBC_OFF_RXADR, 32'h0000_0006);
        rdc("rx status", UBC_OFF_STAT, 32'h0000_0009);
        rx_char_available <= 1'b0;
        // Transmit two chars through a prompt memory
        mem_lat <= 4'h0;
        wb(1'b1, UBC_OFF_TXADR, 32'h0000_0008);
        wb(1'b1, UBC_OFF_TXCNT, 32'h0000_0002);
        tx_holding_free <= 1'b1;
        while (tx_n < 2 || tx_transfer_done !== 1'b1)
            @(posedge sys_clk);
        cyc(20);
        chk("tx fetches", 32'(tx_n), 32'd2);
        chk("tx char 0", 32'(txq[0]), 32'h0000_00c3);
        chk("tx char 1", 32'(txq[1]), 32'h0000_013c);
        rdc("tx addr", UBC_OFF_TXADR, 32'h0000_000a);
        rdc("tx status", UBC_OFF_STAT, 32'h0000_001a);
        tx_holding_free <= 1'b0;
        // Guard length in bit periods, and none at zero
        foreach (gv[i])
        begin
            wb(1'b1, UBC_OFF_GUARD, {24'h0, gv[i]});
            k = tk_n;
            tx_char_sent <= 1'b1;
            @(posedge sys_clk);
            tx_char_sent <= 1'b0;
            cyc(2);
            chk("guard on", 32'(tx_guard_hold), 32'(gv[i] != 0));
            while (tx_guard_hold !== 1'b0)
                @(posedge sys_clk);
            chk("guard bits", 32'(tk_n - k), 32'(gv[i]));
        end
        // Reset with a receive count loaded but no char offered clears that count
        wb(1'b1, UBC_OFF_RXCNT, 32'h0000_0005);
        rst <= 1'b1;
        cyc(3);
        rst <= 1'b0;
        rdc("count reset", UBC_OFF_RXCNT, 32'h0);
        rdc("status reset", UBC_OFF_STAT, 32'h0000_0018);
        test_done();
    end
    // Watchdog: far beyond the few hundred cycles the run needs
    initial
    begin
        #(30000 * 100);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
